// File: include/second_synth_loop_cfg_pkg.sv
// constants for the second synth loop output configuration bank
// assumes registers sit on an apb bus, one aligned 32-bit word each

package second_synth_loop_cfg_pkg;

   // ***************************************************
   // register indices (byte address is four times these)
   // ***************************************************
   localparam logic [5:0] IDX_SPREAD_A   = 6'h20;
   localparam logic [5:0] IDX_SPREAD_B   = 6'h21;
   localparam logic [5:0] IDX_SPREAD_C   = 6'h22;
   localparam logic [5:0] IDX_FREQ_SEL   = 6'h23;
   localparam logic [5:0] IDX_ROUTING    = 6'h24;
   localparam logic [5:0] IDX_STATE_SEL  = 6'h25;
   localparam logic [5:0] IDX_SHAPE_DIV4 = 6'h26;
   localparam logic [5:0] IDX_DIV5       = 6'h27;
   localparam logic [5:0] IDX_STATUS     = 6'h3F;
   localparam logic [6:0] IDX_LIMIT      = 7'h40;

   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [7:0] RST_SPREAD     = 8'h00;
   localparam logic [7:0] RST_FREQ_SEL   = 8'h00;
   localparam logic [7:0] RST_ROUTING    = 8'hED;
   localparam logic [7:0] RST_STATE_SEL  = 8'h02;
   localparam logic [7:0] RST_SHAPE_DIV4 = 8'h01;
   localparam logic [7:0] RST_DIV5       = 8'h01;

   // ***************************************************
   // field positions and masks
   // ***************************************************
   localparam int         BIT_BYPASS     = 7;
   localparam int         BIT_Y4_SRC     = 6;
   localparam int         LSB_Y5_SRC     = 4;
   localparam int         LSB_STATE_ONE  = 2;
   localparam int         LSB_STATE_ZERO = 0;
   localparam int         BIT_SHAPE      = 7;
   localparam int         SPREAD_W       = 3;
   localparam int         DIV_W          = 7;
   localparam logic [7:0] DIV5_WR_MASK   = 8'h7F;

   // ***************************************************
   // encodings
   // ***************************************************
   localparam logic [1:0] Y5_FROM_DIV5   = 2'h2;
   localparam logic [1:0] Y5_RESERVED    = 2'h3;
   localparam logic [1:0] ST_POWER_DOWN  = 2'h0;
   localparam logic [2:0] SPREAD_OFF     = 3'h0;

endpackage

// File: include/setting_sel_if.sv
// carries the synchronised setting index between the pin synchroniser and the bank
// assumes both ends run on the system clock

`timescale 1ns/1ns

interface setting_sel_if #(parameter int W = 3);
   logic [W-1:0] idx;

   modport src (output idx);
   modport dst (input  idx);
endinterface

// File: hdl/control_pin_sync.sv
// three-flop synchroniser for the external control pins
// assumes the pins are asynchronous to clk_sys_in

`timescale 1ns/1ns

module control_pin_sync #(
   parameter int W = 3
) (
   input  wire logic         clk_sys_in,
   input  wire logic         resetn_in,
   input  wire logic [W-1:0] pins_in,
   setting_sel_if.src        sel
);

   // ***************************************************
   // elaboration check
   // ***************************************************
   if (W < 1) begin : g_bad_w
      $error("control_pin_sync needs at least one pin");
   end

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] stable;
   } sync_t;

   sync_t q;
   sync_t d;

   // ***************************************************
   // synchroniser
   // ***************************************************
   // stage one feeds stage two only; a change is taken once two and three agree
   always_comb begin
      d    = q;
      d.s1 = pins_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.stable = q.s3;
      end
   end

   // state register, synchronous reset
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sel.idx = q.stable;

endmodule

// File: hdl/second_synth_loop_output_config_bank.sv
// configuration bank for the second synth loop and clock outputs four and five
// assumes an apb master on clk_sys_in and asynchronous control pins
//
// Overview of operation
// - per-setting 3-bit spread code, 000 off, rising codes raise modulation
// - spread shape bit, 0 down only, 1 centre; resets to 0
// - per-setting frequency bit picks parameter set zero or one; resets 0
// - eight stored settings, control pins choose which one is applied
// - bypass bit 0 routes the loop, 1 bypasses and powers it down; reset 1
// - output four source bit, 0 second divider, 1 fourth; resets to 1
// - output five source 00/01/10 picks divider; 11 reserved; resets 10
// - two output state definitions; reset values 01 and 11
// - per-setting state bit picks definition; only setting one resets to 1
// - fourth divider, 0 standby, 1 to 127 ratio; resets to 1
// - fifth divider, 0 standby, 1 to 127 ratio; resets to 1
// - register bytes are ordered most significant bit first
//
// The implementer's own choice: the APB register port.

`timescale 1ns/1ns

module second_synth_loop_output_config_bank #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk_sys_in,
   input  wire logic              resetn_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   input  wire logic              control_pin_a_in,
   input  wire logic              control_pin_b_in,
   input  wire logic              control_pin_c_in,
   output logic      [2:0]        active_setting_out,
   output logic      [2:0]        spread_amount_field_out,
   output logic                   spread_on_out,
   output logic                   spread_shape_bit_out,
   output logic                   freq_set_select_bit_out,
   output logic                   pll_bypass_select_out,
   output logic                   pll_power_down_out,
   output logic                   fourth_output_source_out,
   output logic      [1:0]        fifth_output_source_out,
   output logic      [1:0]        output_state_out,
   output logic      [6:0]        fourth_output_divider_out,
   output logic                   fourth_div_standby_out,
   output logic      [6:0]        fifth_output_divider_out,
   output logic                   fifth_div_standby_out
);

   // ***************************************************
   // elaboration check
   // ***************************************************
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
      $error("second_synth_loop_output_config_bank needs ADDR_W from 8 to 32");
   end

   typedef struct packed {
      logic [7:0][7:0] regs;
      logic [31:0]     prdata;
      logic            pready;
      logic            slverr;
      logic [2:0]      act;
      logic [2:0]      amt;
      logic            spread_on;
      logic            shape;
      logic            fsel;
      logic            bypass;
      logic            pdown;
      logic            y4src;
      logic [1:0]      y5src;
      logic [1:0]      ystate;
      logic [6:0]      div4;
      logic            div4_stby;
      logic [6:0]      div5;
      logic            div5_stby;
   } bank_t;

   // derived outputs reset to what the register reset values give for setting
   // zero, so the first cycle after release never shows a contradictory pair
   localparam bank_t RESET_STATE = '{
      regs:    {second_synth_loop_cfg_pkg::RST_DIV5, second_synth_loop_cfg_pkg::RST_SHAPE_DIV4,
                second_synth_loop_cfg_pkg::RST_STATE_SEL, second_synth_loop_cfg_pkg::RST_ROUTING,
                second_synth_loop_cfg_pkg::RST_FREQ_SEL, second_synth_loop_cfg_pkg::RST_SPREAD,
                second_synth_loop_cfg_pkg::RST_SPREAD, second_synth_loop_cfg_pkg::RST_SPREAD},
      shape:   second_synth_loop_cfg_pkg::RST_SHAPE_DIV4[second_synth_loop_cfg_pkg::BIT_SHAPE],
      fsel:    second_synth_loop_cfg_pkg::RST_FREQ_SEL[0],
      bypass:  second_synth_loop_cfg_pkg::RST_ROUTING[second_synth_loop_cfg_pkg::BIT_BYPASS],
      pdown:   second_synth_loop_cfg_pkg::RST_ROUTING[second_synth_loop_cfg_pkg::BIT_BYPASS],
      y4src:   second_synth_loop_cfg_pkg::RST_ROUTING[second_synth_loop_cfg_pkg::BIT_Y4_SRC],
      y5src:   second_synth_loop_cfg_pkg::RST_ROUTING[second_synth_loop_cfg_pkg::LSB_Y5_SRC +: 2],
      ystate:  second_synth_loop_cfg_pkg::RST_ROUTING[second_synth_loop_cfg_pkg::LSB_STATE_ZERO +: 2],
      div4:    second_synth_loop_cfg_pkg::RST_SHAPE_DIV4[second_synth_loop_cfg_pkg::DIV_W-1:0],
      div5:    second_synth_loop_cfg_pkg::RST_DIV5[second_synth_loop_cfg_pkg::DIV_W-1:0],
      default: '0
   };

   bank_t q;
   bank_t d;

   // ***************************************************
   // control pin synchroniser
   // ***************************************************
   setting_sel_if #(.W(3)) sel ();

   control_pin_sync #(.W(3)) u_sync (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .pins_in    ({control_pin_c_in, control_pin_b_in, control_pin_a_in}),
      .sel        (sel.src)
   );

   // ***************************************************
   // apb decode
   // ***************************************************
   logic [5:0]  widx;
   logic        hi_zero;
   logic        hit_bank;
   logic        hit_stat;
   logic        setup;
   logic        wr_go;
   logic [2:0]  slot;
   logic [23:0] spread_all;
   logic [7:0]  rd_byte;

   // word index; anything with low bits or high bits set is unmapped
   always_comb begin
      widx     = paddr_in[7:2];
      hi_zero  = ((paddr_in >> 8) == '0) && (paddr_in[1:0] == 2'h0);
      hit_bank = hi_zero && widx >= second_synth_loop_cfg_pkg::IDX_SPREAD_A
                         && widx <= second_synth_loop_cfg_pkg::IDX_DIV5;
      hit_stat = hi_zero && widx == second_synth_loop_cfg_pkg::IDX_STATUS;
      setup    = psel_in && !penable_in;
      wr_go    = psel_in && penable_in && q.pready && pwrite_in && hit_bank;
      slot     = 3'(widx - second_synth_loop_cfg_pkg::IDX_SPREAD_A);
   end

   // eight 3-bit spread codes packed across three bytes, setting seven on top
   assign spread_all = {q.regs[0], q.regs[1], q.regs[2]};

   // read mux; status shows the applied index and power-down state
   always_comb begin
      rd_byte = 8'h00;
      if (hit_bank) begin
         rd_byte = q.regs[slot];
      end else if (hit_stat) begin
         rd_byte = {4'h0, q.pdown, q.act};
      end
   end

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      d        = q;
      // answer in the first access cycle, no wait states
      d.pready = setup;
      d.slverr = setup && !(hit_bank || hit_stat);
      d.prdata = setup ? {24'h000000, rd_byte} : 32'h00000000;

      // low byte lane, bit 7 is the register msb
      if (wr_go) begin
         if (widx == second_synth_loop_cfg_pkg::IDX_DIV5) begin
            d.regs[slot] = pwdata_in[7:0] & second_synth_loop_cfg_pkg::DIV5_WR_MASK;
         end else begin
            d.regs[slot] = pwdata_in[7:0];
         end
      end

      // applied index, spread code, frequency bit and state pick follow the synchronised pins
      d.act       = sel.idx;
      d.amt       = spread_all[sel.idx * second_synth_loop_cfg_pkg::SPREAD_W +: 3];
      d.spread_on = d.amt != second_synth_loop_cfg_pkg::SPREAD_OFF;
      d.shape     = q.regs[6][second_synth_loop_cfg_pkg::BIT_SHAPE];
      d.fsel      = q.regs[3][sel.idx];
      d.bypass    = q.regs[4][second_synth_loop_cfg_pkg::BIT_BYPASS];
      d.y4src     = q.regs[4][second_synth_loop_cfg_pkg::BIT_Y4_SRC];
      d.y5src     = q.regs[4][second_synth_loop_cfg_pkg::LSB_Y5_SRC +: 2];
      // the reserved code would select nothing; fall back to the fifth divider
      if (d.y5src == second_synth_loop_cfg_pkg::Y5_RESERVED) begin
         d.y5src = second_synth_loop_cfg_pkg::Y5_FROM_DIV5;
      end
      if (q.regs[5][sel.idx]) begin
         d.ystate = q.regs[4][second_synth_loop_cfg_pkg::LSB_STATE_ONE +: 2];
      end else begin
         d.ystate = q.regs[4][second_synth_loop_cfg_pkg::LSB_STATE_ZERO +: 2];
      end
      d.pdown     = d.bypass || d.ystate == second_synth_loop_cfg_pkg::ST_POWER_DOWN;
      d.div4      = q.regs[6][second_synth_loop_cfg_pkg::DIV_W-1:0];
      d.div4_stby = d.div4 == 7'h00;
      d.div5      = q.regs[7][second_synth_loop_cfg_pkg::DIV_W-1:0];
      d.div5_stby = d.div5 == 7'h00;
   end

   // state register, synchronous reset
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   // ***************************************************
   // outputs, all from q
   // ***************************************************
   assign prdata_out                = q.prdata;
   assign pready_out                = q.pready;
   assign pslverr_out               = q.slverr;
   assign active_setting_out        = q.act;
   assign spread_amount_field_out   = q.amt;
   assign spread_on_out             = q.spread_on;
   assign spread_shape_bit_out      = q.shape;
   assign freq_set_select_bit_out   = q.fsel;
   assign pll_bypass_select_out     = q.bypass;
   assign pll_power_down_out        = q.pdown;
   assign fourth_output_source_out  = q.y4src;
   assign fifth_output_source_out   = q.y5src;
   assign output_state_out          = q.ystate;
   assign fourth_output_divider_out = q.div4;
   assign fourth_div_standby_out    = q.div4_stby;
   assign fifth_output_divider_out  = q.div5;
   assign fifth_div_standby_out     = q.div5_stby;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);

   sequence s_wr_setup(logic [5:0] ix);
      psel_in && !penable_in && pwrite_in && paddr_in == {ix, 2'h0};
   endsequence

   sequence s_access;
      psel_in && penable_in;
   endsequence

   // a write to the shape register shows on the shape output two edges on
   property p_shape_write;
      s_wr_setup(second_synth_loop_cfg_pkg::IDX_SHAPE_DIV4) ##1 s_access
         |-> ##2 spread_shape_bit_out == $past(pwdata_in[7], 2);
   endproperty

   // a write to the fifth divider never keeps the reserved bit
   property p_div5_write;
      s_wr_setup(second_synth_loop_cfg_pkg::IDX_DIV5) ##1 s_access
         |=> q.regs[7] == ($past(pwdata_in[7:0]) & 8'h7F);
   endproperty

   // a set state bit of the applied setting picks definition one
   property p_state_pick;
      q.regs[5][sel.idx] && $stable(q.regs[4])
         |=> output_state_out == $past(q.regs[4][3:2]);
   endproperty

   // a held pin pattern reaches the applied index within five edges
   property p_pin_follow;
      ($stable({control_pin_c_in, control_pin_b_in, control_pin_a_in}))[*5]
         |-> active_setting_out == {$past(control_pin_c_in, 5),
                                    $past(control_pin_b_in, 5),
                                    $past(control_pin_a_in, 5)};
   endproperty

   a_shape_write: assert property (p_shape_write)
      else $error("shape output did not follow write");
   a_div5_rsvd: assert property (p_div5_write)
      else $error("fifth divider write kept reserved bit");
   a_state_pick: assert property (p_state_pick)
      else $error("state definition one not applied");
   a_pin_index: assert property (p_pin_follow)
      else $error("applied index does not match pins");
   a_bypass_pdown: assert property (pll_bypass_select_out |-> pll_power_down_out)
      else $error("bypass without power down");
   a_state_pdown: assert property (output_state_out == 2'h0 |-> pll_power_down_out)
      else $error("state 00 without power down");
   a_y5_no_rsvd: assert property (fifth_output_source_out != 2'h3)
      else $error("reserved output five source applied");
   a_div4_stby: assert property (
      fourth_div_standby_out == (fourth_output_divider_out == 7'h00))
      else $error("fourth divider standby mismatch");
   a_div5_stby: assert property (
      $changed(q.regs[7]) |=> fifth_div_standby_out == (q.regs[7][6:0] == 7'h00))
      else $error("fifth divider standby mismatch");
   // the enable flag has to agree with the code that is actually applied
   a_spread_on: assert property (
      spread_on_out == (spread_amount_field_out != 3'h0))
      else $error("spread enable does not match code");
   // the status word is mapped even though it sits past the bank
   a_unmapped_err: assert property (
      psel_in && !penable_in && paddr_in[7:2] >= 6'h28
         && paddr_in[7:2] != second_synth_loop_cfg_pkg::IDX_STATUS |=> pslverr_out)
      else $error("unmapped address without error");
   // a write may commit on the same edge; compare with the byte then in force
   a_freq_apply: assert property (
      $stable(q.regs[3]) && $stable(sel.idx)
         |=> freq_set_select_bit_out == $past(q.regs[3][sel.idx]))
      else $error("frequency set bit not applied");
   // an error answer only ever rides on the ready pulse
   a_err_ready: assert property (pslverr_out |-> pready_out)
      else $error("error response without ready");
   // the reserved top bit of the fifth divider is never stored
   a_div5_top: assert property (q.regs[7][7] == 1'b0)
      else $error("fifth divider reserved bit stored");

endmodule

// File: tb/setting_pin_driver.sv
// partner model: host-side driver of the three setting select pins
// assumes it shares clk_sys_in with the bank and moves after a clock edge

`timescale 1ns/1ns

module setting_pin_driver (
   input  wire logic       clk_sys_in,
   input  wire logic [2:0] want_in,
   input  wire logic [3:0] lag_in,
   output logic            pin_a_out,
   output logic            pin_b_out,
   output logic            pin_c_out
);
   logic [3:0] wait_q = 4'h0;
   logic [2:0] held_q = 3'h0;

   // ************************************************
   // pins move once the lag runs out, then stay still
   // ************************************************
   always @(posedge clk_sys_in) begin
      if (want_in != held_q && wait_q < lag_in) begin
         wait_q <= wait_q + 4'h1;
      end else begin
         held_q <= want_in;
         wait_q <= 4'h0;
      end
   end

   // index bit 0 rides on pin a
   assign {pin_c_out, pin_b_out, pin_a_out} = held_q;
endmodule

// File: tb/second_synth_loop_output_config_bank_tb_top.sv
// self-checking bench for the second synth loop configuration bank
// assumes a zero-wait apb slave and a pin partner on the same clock

`timescale 1ns/1ns

module second_synth_loop_output_config_bank_tb_top;
   logic        clk_sys_in = 1'b0;
   logic        resetn_in  = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, r;
   logic        pready, pslverr, e, pa, pb, pc;
   logic [2:0]  want = 3'h0, act, amt, x;
   logic [3:0]  lag = 4'h0;
   logic        on, shp, fs, byp, pd, y4, s4, s5;
   logic [1:0]  y5, st;
   logic [6:0]  d4, d5;
   logic [7:0]  m [8];
   logic [7:0]  v;
   logic [39:0] ex;
   logic [31:0] seed = 32'h0001_4A2B;
   int          err_count = 0;
   int          compares  = 0;
   logic [7:0]  dir [8] = '{8'hFA, 8'hC6, 8'h88, 8'h5A, 8'h10, 8'hA5, 8'h80, 8'h00};

   always #2 clk_sys_in = ~clk_sys_in;

   second_synth_loop_output_config_bank #(.ADDR_W(8)) u_dut (
      .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .control_pin_a_in(pa), .control_pin_b_in(pb),
      .control_pin_c_in(pc), .active_setting_out(act),
      .spread_amount_field_out(amt), .spread_on_out(on),
      .spread_shape_bit_out(shp), .freq_set_select_bit_out(fs),
      .pll_bypass_select_out(byp), .pll_power_down_out(pd),
      .fourth_output_source_out(y4), .fifth_output_source_out(y5),
      .output_state_out(st), .fourth_output_divider_out(d4),
      .fourth_div_standby_out(s4), .fifth_output_divider_out(d5),
      .fifth_div_standby_out(s5));

   setting_pin_driver u_pins (
      .clk_sys_in(clk_sys_in), .want_in(want), .lag_in(lag),
      .pin_a_out(pa), .pin_b_out(pb), .pin_c_out(pc));

   // ************************************************
   // helpers: random source, reference model, compares
   // ************************************************
   function logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // applied outputs of setting i, from the modelled register bytes
   function logic [39:0] exp_out(input logic [2:0] i);
      logic [23:0] spr;
      logic [2:0]  a;
      logic [1:0]  s, y;
      spr = {m[0], m[1], m[2]};
      a   = spr[3*i +: 3];
      s   = m[5][i] ? m[4][3:2] : m[4][1:0];
      y   = (m[4][5:4] == 2'h3) ? 2'h2 : m[4][5:4];
      return {8'h00, i, a, a != 3'h0, m[6][7], m[3][i], m[4][7],
              m[4][7] | (s == 2'h0), m[4][6], y, s, m[6][6:0],
              m[6][6:0] == 7'h00, m[7][6:0], m[7][6:0] == 7'h00};
   endfunction

   task automatic chk_reg(input logic [31:0] xp, input logic [31:0] g);
      compares++;
      if (g !== xp) begin
         err_count++;
         $display("unexpected at %0t exp %h got %h", $time, xp, g);
      end
   endtask

   task automatic chk_out(input logic [39:0] xp, input logic [39:0] g);
      compares++;
      if (g !== xp) begin
         err_count++;
         $display("unexpected at %0t exp %h got %h", $time, xp, g);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_sys_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge clk_sys_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) err_count++;
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic conclude;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ************************************************
   // main sequence: reset view, directed, then random
   // ************************************************
   initial begin
      m = '{8'h00, 8'h00, 8'h00, 8'h00, second_synth_loop_cfg_pkg::RST_ROUTING,
            second_synth_loop_cfg_pkg::RST_STATE_SEL, second_synth_loop_cfg_pkg::RST_SHAPE_DIV4,
            second_synth_loop_cfg_pkg::RST_DIV5};
      repeat (3) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      for (int rnd = 0; rnd < 6; rnd++) begin
         for (int i = 0; i < 8; i++) begin
            if (rnd > 0) begin
               seed = lfsr_next(seed);
               v = (rnd == 1) ? dir[i] : seed[7:0];
               if (i == 7) v[7] = 1'b0;
               if (i == 4 && v[5:4] == 2'h3) v[4] = 1'b0;
               apb(1'b1, 8'h80 + 8'(4 * i), v);
               m[i] = v;
               chk_reg(32'h0, {31'h0, e});
            end
         end
         // read back every byte; round zero checks reset values
         for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'h80 + 8'(4 * i), 8'h00);
            chk_reg({24'h00_0000, m[i]}, r);
         end
         // sweep all eight settings through the pins, slow and prompt
         for (int i = 0; i < 8; i++) begin
            x = 3'(i);
            seed = lfsr_next(seed);
            want <= x;
            lag  <= seed[3:0];
            for (int n = 0; n < 40 && act !== x; n++) @(posedge clk_sys_in);
            @(posedge clk_sys_in);
            ex = exp_out(x);
            chk_out(ex, {8'h00, act, amt, on, shp, fs, byp, pd, y4, y5, st,
                         d4, s4, d5, s5});
            apb(1'b0, 8'hFC, 8'h00);
            chk_reg({28'h000_0000, ex[21], x}, r);
         end
      end
      // an address that holds no register answers with an error
      apb(1'b0, 8'hA0, 8'h00);
      chk_reg(32'h0, r);
      chk_reg(32'h1, {31'h0, e});
      conclude;
   end

   // a hang counts as a mismatch and ends the run the same way
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      err_count++;
      conclude;
   end
endmodule
